// ==== core/ebr_arbiter.sv ====
`timescale 1ns/10ps
module ebr_arbiter #(
	parameter int ADDR_W = ebr_pkg::ADDR_W,
	parameter int DATA_W = ebr_pkg::DATA_W
) (
	// Peripheral clock and power-on reset (not the device reset pin).
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Device reset pin level; the handshake ignores it.
	input wire logic dev_reset_n_in,
	// External master handshake.
	input wire logic ext_bus_request_n_in,
	output logic ext_bus_grant_n_out,
	output logic grant_hang_n_out,
	// Internal requesters for the external port.
	input wire logic core_req_in,
	input wire logic periph_req_in,
	input wire logic dual_read_hold_in,
	input wire logic core_exclusive_in,
	output logic core_stall_out,
	// Port drivers from the memory interface.
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic data_drive_in,
	input wire logic [ebr_pkg::MSEL_W-1:0] memory_selects_in,
	input wire logic boot_space_select_in,
	input wire logic io_space_select_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	// Pads.
	output logic [ADDR_W-1:0] addr_out,
	output logic addr_oe_out,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_out,
	output logic [ebr_pkg::MSEL_W-1:0] memory_selects_out,
	output logic boot_space_select_out,
	output logic io_space_select_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic ctrl_oe_out
);
	ebr_sync_if sif ();
	ebr_pkg::ebr_state_t state_ff;
	ebr_pkg::ebr_state_t nxt_state;
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic grant_n_ff;
	logic hang_n_ff;
	logic stall_ff;
	logic oe_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] data_ff;
	logic data_oe_ff;
	logic [ebr_pkg::MSEL_W-1:0] ms_ff;
	logic bms_ff;
	logic io_space_select_ff;
	logic rd_ff;
	logic wr_ff;
	logic ext_req;
	logic int_pending;
	logic may_grant;
	logic bus_away;
	logic blocked;

	assign sif.req_raw_n = ext_bus_request_n_in;
	ebr_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.sif(sif.syncer)
	);

	// The device reset pin deliberately does not enter this logic.
	assign ext_req = ~sif.req_sync_n;
	assign int_pending = core_req_in | periph_req_in;
	// Dual-read lock blocks grant; a read/write pair leaves it open.
	assign may_grant = ext_req & ~int_pending & ~dual_read_hold_in;
	assign bus_away = (state_ff == ebr_pkg::ST_RELEASE) || (state_ff == ebr_pkg::ST_GRANTED);
	// Exclusive mode only drops peripheral requests from what stalls the core; bus requests are still granted.
	assign blocked = bus_away & (core_req_in | (periph_req_in & ~core_exclusive_in));

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ebr_pkg::ST_OWN: begin
				nxt_cnt = ebr_pkg::CNT_W2_ZERO;
				if (ext_req) begin
					nxt_state = ebr_pkg::ST_WAIT;
				end
			end
			ebr_pkg::ST_WAIT: begin
				if (!ext_req) begin
					nxt_state = ebr_pkg::ST_OWN;
				end else if (cnt_ff != ebr_pkg::GRANT_CNT_LAST) begin
					nxt_cnt = cnt_ff + ebr_pkg::CNT_W2_ONE;
				end else if (may_grant) begin
					nxt_state = ebr_pkg::ST_RELEASE;
				end
			end
			ebr_pkg::ST_RELEASE: begin
				nxt_state = ext_req ? ebr_pkg::ST_GRANTED : ebr_pkg::ST_OWN;
			end
			ebr_pkg::ST_GRANTED: begin
				if (!ext_req) begin
					nxt_state = ebr_pkg::ST_OWN;
				end
			end
			default: begin
				nxt_state = ebr_pkg::ST_OWN;
			end
		endcase
	end

	// Runs on the peripheral clock; rate selection is upstream.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= ebr_pkg::ST_OWN;
			cnt_ff <= ebr_pkg::CNT_W2_ZERO;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_ff <= 1'b1;
			grant_n_ff <= 1'b1;
			hang_n_ff <= 1'b1;
			stall_ff <= 1'b0;
		end else begin
			oe_ff <= (nxt_state == ebr_pkg::ST_OWN) || (nxt_state == ebr_pkg::ST_WAIT);
			grant_n_ff <= nxt_state != ebr_pkg::ST_GRANTED;
			hang_n_ff <= ~blocked;
			stall_ff <= blocked;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_ff <= '0;
			data_ff <= '0;
			data_oe_ff <= 1'b0;
			ms_ff <= '1;
			bms_ff <= 1'b1;
			io_space_select_ff <= 1'b1;
			rd_ff <= 1'b1;
			wr_ff <= 1'b1;
		end else begin
			addr_ff <= addr_in;
			data_ff <= wdata_in;
			data_oe_ff <= data_drive_in & ((nxt_state == ebr_pkg::ST_OWN) ||
				(nxt_state == ebr_pkg::ST_WAIT));
			ms_ff <= memory_selects_in;
			bms_ff <= boot_space_select_in;
			io_space_select_ff <= io_space_select_in;
			rd_ff <= rd_n_in;
			wr_ff <= wr_n_in;
		end
	end

	assign ext_bus_grant_n_out = grant_n_ff;
	assign grant_hang_n_out = hang_n_ff;
	assign core_stall_out = stall_ff;
	assign addr_out = addr_ff;
	assign addr_oe_out = oe_ff;
	assign data_out = data_ff;
	assign data_oe_out = data_oe_ff;
	assign memory_selects_out = ms_ff;
	assign boot_space_select_out = bms_ff;
	assign io_space_select_out = io_space_select_ff;
	assign rd_n_out = rd_ff;
	assign wr_n_out = wr_ff;
	assign ctrl_oe_out = oe_ff;

	property p_grant_after_release;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$fell(ext_bus_grant_n_out) |-> !$past(ctrl_oe_out);
	endproperty
	a_grant_after_release: assert property (p_grant_after_release)
		else $error("grant before release");

	property p_no_drive_granted;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!ext_bus_grant_n_out |-> !addr_oe_out && !data_oe_out && !ctrl_oe_out;
	endproperty
	a_no_drive_granted: assert property (p_no_drive_granted)
		else $error("driving while granted");

	property p_min_latency;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$fell(ext_bus_request_n_in) ##1 ext_bus_request_n_in == 1'b0 |-> ext_bus_grant_n_out [*3];
	endproperty
	a_min_latency: assert property (p_min_latency) else $error("grant too early");

	property p_grant_needs_idle;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		$fell(ctrl_oe_out) |->
			!$past(core_req_in) && !$past(periph_req_in) && !$past(dual_read_hold_in);
	endproperty
	a_grant_needs_idle: assert property (p_grant_needs_idle)
		else $error("grant over internal");

	property p_release;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(!ext_bus_grant_n_out && ext_bus_request_n_in) [*3] |=> ext_bus_grant_n_out && ctrl_oe_out;
	endproperty
	a_release: assert property (p_release) else $error("grant not returned");

	property p_hang;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(bus_away && core_req_in) |=> !grant_hang_n_out && core_stall_out;
	endproperty
	a_hang: assert property (p_hang) else $error("hang not flagged");

	property p_stall_only_away;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		core_stall_out |-> $past(bus_away);
	endproperty
	a_stall_only_away: assert property (p_stall_only_away) else $error("stray stall");

	property p_sync;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ext_req |-> !$past(ext_bus_request_n_in, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("sync depth wrong");

	// The device reset pin must never hold the bus away from a master that has let go.
	property p_grant_in_rst;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		(!dev_reset_n_in && !ext_bus_grant_n_out && !ext_req) |=> ext_bus_grant_n_out;
	endproperty
	a_grant_in_rst: assert property (p_grant_in_rst) else $error("stuck in reset");
endmodule : ebr_arbiter

// ==== core/ebr_pkg.sv ====
package ebr_pkg;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int MSEL_W = 4;
	localparam int SYNC_STAGES = 2;
	// Least request-to-grant spacing in peripheral clock cycles.
	localparam int GRANT_MIN_CYC = 3;
	localparam logic [1:0] CNT_W2_ZERO = 2'h0;
	localparam logic [1:0] CNT_W2_ONE = 2'h1;
	localparam logic [1:0] GRANT_CNT_LAST = 2'h1;
	typedef enum logic [3:0] {
		ST_OWN = 4'h1,
		ST_WAIT = 4'h2,
		ST_RELEASE = 4'h4,
		ST_GRANTED = 4'h8
	} ebr_state_t;
endpackage : ebr_pkg

// ==== core/ebr_sync.sv ====
`timescale 1ns/10ps
module ebr_sync (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Request levels.
	ebr_sync_if.syncer sif
);
	logic meta_ff;
	logic sync_ff;
	// Resets to idle (request not asserted); only the second stage is read outside.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= sif.req_raw_n;
			sync_ff <= meta_ff;
		end
	end
	assign sif.req_sync_n = sync_ff;
endmodule : ebr_sync

// ==== core/ebr_sync_if.sv ====
`timescale 1ns/10ps
interface ebr_sync_if;
	logic req_raw_n;
	logic req_sync_n;
	modport producer (input req_sync_n, output req_raw_n);
	modport syncer (input req_raw_n, output req_sync_n);
endinterface : ebr_sync_if

// ==== sim/ebr_master_model.sv ====
`timescale 1ns/10ps
module ebr_master_model (
	// Clock.
	input wire logic clk_sys_in,
	// Request to the device.
	output logic ext_bus_request_n_out
);
	initial ext_bus_request_n_out = 1'b1;
	task automatic ask();
		@(negedge clk_sys_in);
		ext_bus_request_n_out = 1'b0;
	endtask : ask
	task automatic let_go();
		@(negedge clk_sys_in);
		ext_bus_request_n_out = 1'b1;
	endtask : let_go
endmodule : ebr_master_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic clk_sys_in, rst_n_in, dev_n, req_n, gnt_n, hang_n, creq, preq, dual, excl, stall;
	logic a_oe, d_oe, c_oe, rd_n, wr_n, bsel, periph_clock_half_select;
	logic [ebr_pkg::ADDR_W-1:0] pat, addr;
	logic [ebr_pkg::DATA_W-1:0] data;
	logic [ebr_pkg::MSEL_W-1:0] msel;
	int failures, samples_checked, n;
	ebr_master_model m (.clk_sys_in(clk_sys_in), .ext_bus_request_n_out(req_n));
	ebr_arbiter dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .dev_reset_n_in(dev_n),
		.ext_bus_request_n_in(req_n), .ext_bus_grant_n_out(gnt_n), .grant_hang_n_out(hang_n),
		.core_req_in(creq), .periph_req_in(preq), .dual_read_hold_in(dual),
		.core_exclusive_in(excl), .core_stall_out(stall), .addr_in(pat),
		.wdata_in(pat[15:0]), .data_drive_in(pat[4]), .memory_selects_in(pat[3:0]),
		.boot_space_select_in(pat[0]), .io_space_select_in(pat[1]), .rd_n_in(pat[2]),
		.wr_n_in(pat[3]), .addr_out(addr), .addr_oe_out(a_oe), .data_out(data),
		.data_oe_out(d_oe), .memory_selects_out(msel), .boot_space_select_out(bsel),
		.io_space_select_out(periph_clock_half_select), .rd_n_out(rd_n), .wr_n_out(wr_n), .ctrl_oe_out(c_oe));
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wait_g(logic v, int lim);
		n = 0;
		while (gnt_n !== v && n < lim) begin
			@(negedge clk_sys_in);
			n++;
		end
		chk("grant_n", {31'h0, v}, {31'h0, gnt_n});
	endtask : wait_g
	task automatic end_sim();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic s_grant();
		m.ask();
		wait_g(1'b0, 20);
		chk("grant_delay", 32'h1, {31'h0, n >= ebr_pkg::GRANT_MIN_CYC});
		chk("oe", 32'h0, {29'h0, a_oe, c_oe, d_oe});
		m.let_go();
		wait_g(1'b1, 10);
		@(negedge clk_sys_in);
		chk("oe_back", 32'h3, {30'h0, a_oe, c_oe});
		chk("addr", {10'h0, pat}, {10'h0, addr});
		chk("strobes", {28'h0, pat[3:0]}, {28'h0, wr_n, rd_n, periph_clock_half_select, bsel});
		chk("selects", {28'h0, pat[3:0]}, {28'h0, msel});
		chk("data", {16'h0, pat[15:0]}, {16'h0, data});
		chk("data_oe", {31'h0, pat[4]}, {31'h0, d_oe});
	endtask : s_grant
	task automatic blocked_by(logic c, logic p, logic d);
		creq = c;
		preq = p;
		dual = d;
		m.ask();
		repeat (15) @(negedge clk_sys_in);
		chk("held_off", 32'h1, {31'h0, gnt_n});
		creq = 1'b0;
		preq = 1'b0;
		dual = 1'b0;
		wait_g(1'b0, 20);
		m.let_go();
		wait_g(1'b1, 10);
	endtask : blocked_by
	task automatic s_prio();
		blocked_by(1'b1, 1'b0, 1'b0);
		blocked_by(1'b0, 1'b1, 1'b0);
	endtask : s_prio
	task automatic s_dual();
		blocked_by(1'b0, 1'b0, 1'b1);
	endtask : s_dual
	task automatic s_stall();
		m.ask();
		wait_g(1'b0, 20);
		creq = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		chk("stall_hang", 32'h2, {30'h0, stall, hang_n});
		creq = 1'b0;
		excl = 1'b1;
		preq = 1'b1;
		repeat (3) @(negedge clk_sys_in);
		chk("excl_hang", 32'h1, {30'h0, stall, hang_n});
		preq = 1'b0;
		excl = 1'b0;
		creq = 1'b1;
		m.let_go();
		wait_g(1'b1, 10);
		repeat (3) @(negedge clk_sys_in);
		chk("resume", 32'h1, {30'h0, stall, hang_n});
		creq = 1'b0;
	endtask : s_stall
	task automatic s_devrst();
		dev_n = 1'b0;
		m.ask();
		wait_g(1'b0, 20);
		m.let_go();
		wait_g(1'b1, 10);
		dev_n = 1'b1;
	endtask : s_devrst
	initial begin
		#400000;
		failures++;
		end_sim();
	end
	initial begin
		{creq, preq, dual, excl} = 4'h0;
		dev_n = 1'b1;
		pat = 22'h2AAAA4;
		rst_n_in = 1'b0;
		repeat (6) @(negedge clk_sys_in);
		chk("reset_out", 32'h3, {30'h0, gnt_n, hang_n});
		rst_n_in = 1'b1;
		s_grant();
		pat = 22'h15555B;
		s_grant();
		s_prio();
		s_dual();
		s_stall();
		s_devrst();
		end_sim();
	end
endmodule : tb
